// >>> rtl/sutc_top.sv
// Receive user-bit buffer configuration and transmitter control block
`timescale 1ns/1ps
module sutc_top
    import sutc_pkg::*;
#(
    parameter logic [6:0] TAPE_CATEGORY = TAPE_CATEGORY_DEF,
    parameter int LEN_SMALL = UB_LEN_SMALL,
    parameter int LEN_LARGE = UB_LEN_LARGE
) (
    input wire logic clk,
    input wire logic arst_n,
    // Control register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Decoded receive subframes
    input wire logic rx_stb,
    input wire logic rx_chan_b,
    input wire logic rx_zpre,
    input wire logic rx_user_bit,
    input wire logic rx_cs_bit,
    // User-bit buffer read side
    input wire logic [$clog2(LEN_LARGE)-1:0] ub_rd_addr,
    output logic ub_rd_data,
    // Event flags
    output logic rx_cs_block_flag,
    input wire logic rx_cs_flag_clr,
    output logic ub_irq_flag,
    input wire logic ub_irq_clr,
    // Transmit subframe stream
    input wire logic tx_sf_valid,
    input wire logic [31:0] tx_sf_data,
    output logic tx_out_valid,
    output logic [31:0] tx_out_data,
    output logic tx_frame_tick,
    output logic [2:0] tx_clk_sel_oh,
    output logic [2:0] tx_rate_ratio,
    output logic tx_on
);
    //--------------------------------------------------------------------------
    // Register state
    //--------------------------------------------------------------------------
    logic userbit_irq_id_only;
    logic rx_userbit_split_store;
    logic cs_irq_change_mode;
    logic [1:0] rx_userbit_buffer_mode;
    logic rx_userbit_buffer_size;
    logic tx_validity_ctl;
    logic [1:0] tx_clock_select;
    logic [2:0] ratio_wr;
    logic [1:0] clksel_wr;
    logic ratio_ok, clksel_ok;
    logic [DATA_W-1:0] rxbuf_rd, txctl_rd;

    // Reserved ratio and clock codes are screened before they land
    function automatic logic ratio_legal(input logic [2:0] code);
        ratio_legal = (code == RATIO_1_1) || (code == RATIO_1_2) || (code == RATIO_1_4) ||
                      (code == RATIO_2_1) || (code == RATIO_4_1);
    endfunction

    assign ratio_wr = reg_wdata[TX_RATIO_LSB +: 3];
    assign clksel_wr = reg_wdata[TX_CLKSEL_LSB +: 2];
    assign ratio_ok = ratio_legal(ratio_wr);
    assign clksel_ok = (clksel_wr != 2'h3);

    // Receiver buffer configuration register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            userbit_irq_id_only <= RXBUF_CFG_RST[UB_ID_ONLY_POS];
            rx_userbit_split_store <= RXBUF_CFG_RST[UB_SPLIT_POS];
            cs_irq_change_mode <= RXBUF_CFG_RST[CS_CHG_POS];
            rx_userbit_buffer_mode <= RXBUF_CFG_RST[UB_MODE_LSB +: 2];
            rx_userbit_buffer_size <= RXBUF_CFG_RST[UB_SIZE_POS];
        end else if (reg_wr && reg_addr == RXBUF_CFG_ADDR) begin
            userbit_irq_id_only <= reg_wdata[UB_ID_ONLY_POS];
            rx_userbit_split_store <= reg_wdata[UB_SPLIT_POS];
            cs_irq_change_mode <= reg_wdata[CS_CHG_POS];
            rx_userbit_buffer_mode <= reg_wdata[UB_MODE_LSB +: 2];
            rx_userbit_buffer_size <= reg_wdata[UB_SIZE_POS];
        end
    end

    // Transmitter control; a reserved code leaves its field alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_validity_ctl <= TX_CTRL_RST[TX_VALID_POS];
            tx_rate_ratio <= TX_CTRL_RST[TX_RATIO_LSB +: 3];
            tx_clock_select <= TX_CTRL_RST[TX_CLKSEL_LSB +: 2];
            tx_on <= TX_CTRL_RST[TX_ON_POS];
        end else if (reg_wr && reg_addr == TX_CTRL_ADDR) begin
            tx_validity_ctl <= reg_wdata[TX_VALID_POS];
            tx_on <= reg_wdata[TX_ON_POS];
            if (ratio_ok) tx_rate_ratio <= ratio_wr;
            if (clksel_ok) tx_clock_select <= clksel_wr;
        end
    end

    //--------------------------------------------------------------------------
    // Read-back
    //--------------------------------------------------------------------------
    // Reserved bits assemble as zero
    always_comb begin
        rxbuf_rd = '0;
        rxbuf_rd[UB_ID_ONLY_POS] = userbit_irq_id_only;
        rxbuf_rd[UB_SPLIT_POS] = rx_userbit_split_store;
        rxbuf_rd[CS_CHG_POS] = cs_irq_change_mode;
        rxbuf_rd[UB_MODE_LSB +: 2] = rx_userbit_buffer_mode;
        rxbuf_rd[UB_SIZE_POS] = rx_userbit_buffer_size;
        txctl_rd = '0;
        txctl_rd[TX_VALID_POS] = tx_validity_ctl;
        txctl_rd[TX_RATIO_LSB +: 3] = tx_rate_ratio;
        txctl_rd[TX_CLKSEL_LSB +: 2] = tx_clock_select;
        txctl_rd[TX_ON_POS] = tx_on;
    end

    // Registered read data, held between reads; unmapped reads zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                RXBUF_CFG_ADDR: reg_rdata <= rxbuf_rd;
                TX_CTRL_ADDR: reg_rdata <= txctl_rd;
                default: reg_rdata <= '0;
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // Receive path
    //--------------------------------------------------------------------------
    sutc_rx_if rx_bus ();
    logic cs_evt, ub_full, ub_start, professional_flag, start_prev_r, ub_evt, tape_mode;
    logic [7:0] byte1;

    // Subframes come from logic on this clock, so no synchroniser
    assign rx_bus.stb = rx_stb;
    assign rx_bus.chan_b = rx_chan_b;
    assign rx_bus.zpre = rx_zpre;
    assign rx_bus.user_bit = rx_user_bit;
    assign rx_bus.cs_bit = rx_cs_bit;

    sutc_cs_monitor u_cs (
        .clk,
        .arst_n,
        .rx(rx_bus),
        .chg_mode(cs_irq_change_mode),
        .blk_evt(cs_evt),
        .pro_r(professional_flag),
        .byte1_r(byte1)
    );

    sutc_userbit_buf #(
        .LEN_SMALL(LEN_SMALL),
        .LEN_LARGE(LEN_LARGE)
    ) u_ub (
        .clk,
        .arst_n,
        .rx(rx_bus),
        .mode(rx_userbit_buffer_mode),
        .split(rx_userbit_split_store),
        .size_large(rx_userbit_buffer_size),
        .professional_flag(professional_flag),
        .pro_code(byte1[7:4]),
        .rd_addr(ub_rd_addr),
        .rd_data(ub_rd_data),
        .full_evt(ub_full),
        .start_bit_r(ub_start)
    );

    // Tape category counts only in consumer format
    assign tape_mode = userbit_irq_id_only && !professional_flag && (byte1[6:0] == TAPE_CATEGORY);
    assign ub_evt = ub_full && (!tape_mode || ub_start != start_prev_r);

    // Start bit of the previous full buffer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) start_prev_r <= 1'b0;
        else if (ub_full) start_prev_r <= ub_start;
    end

    // Sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_cs_block_flag <= 1'b0;
            ub_irq_flag <= 1'b0;
        end else begin
            if (cs_evt) rx_cs_block_flag <= 1'b1;
            else if (rx_cs_flag_clr) rx_cs_block_flag <= 1'b0;
            if (ub_evt) ub_irq_flag <= 1'b1;
            else if (ub_irq_clr) ub_irq_flag <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // Transmit path
    //--------------------------------------------------------------------------
    logic [31:0] sf_mod;
    logic [1:0] div_r, burst_r;
    logic rx_frame;

    // One-hot select for the clock mux outside
    always_comb begin
        case (tx_clock_select)
            CLK_INT1: tx_clk_sel_oh = 3'h1;
            CLK_INT2: tx_clk_sel_oh = 3'h2;
            CLK_RECOV: tx_clk_sel_oh = 3'h4;
            default: tx_clk_sel_oh = 3'h1; // Reserved code never stored
        endcase
    end

    // Insert validity, redo even parity over bits 4..30
    always_comb begin
        sf_mod = tx_sf_data;
        sf_mod[SF_VALID_POS] = tx_validity_ctl;
        sf_mod[SF_PARITY_POS] = ^sf_mod[SF_PARITY_POS-1:4];
    end

    // Outgoing subframes only while enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_out_valid <= 1'b0;
            tx_out_data <= '0;
        end else begin
            tx_out_valid <= tx_on && tx_sf_valid;
            if (tx_on && tx_sf_valid) tx_out_data <= sf_mod;
        end
    end

    assign rx_frame = rx_stb && rx_chan_b;

    // Frame pacing: divide receive frames or burst ticks per frame
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 2'h0;
            burst_r <= 2'h0;
            tx_frame_tick <= 1'b0;
        end else if (!tx_on) begin
            div_r <= 2'h0;
            burst_r <= 2'h0;
            tx_frame_tick <= 1'b0;
        end else if (rx_frame) begin
            div_r <= div_r + 2'h1;
            tx_frame_tick <= 1'b0;
            case (tx_rate_ratio)
                RATIO_1_1: tx_frame_tick <= 1'b1;
                RATIO_1_2: tx_frame_tick <= div_r[0];
                RATIO_1_4: tx_frame_tick <= (div_r == 2'h3);
                RATIO_2_1: begin
                    tx_frame_tick <= 1'b1;
                    burst_r <= 2'h1;
                end
                RATIO_4_1: begin
                    tx_frame_tick <= 1'b1;
                    burst_r <= 2'h3;
                end
                default: tx_frame_tick <= 1'b1;
            endcase
        end else if (burst_r != 2'h0) begin
            tx_frame_tick <= 1'b1;
            burst_r <= burst_r - 2'h1;
        end else begin
            tx_frame_tick <= 1'b0;
        end
    end
endmodule // sutc_top

// >>> rtl/sutc_pkg.sv
// Constants, register map and codes for user-bit and transmit control
//------------------------------------------------------------------------------
// Operation
// - ID-only, consumer, tape category: user-bit event only on start-bit change
// - Split 0 stores A/B user bits interleaved, 1 in separate areas
// - Change-mode 0: flag after every complete 192-frame status block
// - Change-mode 1: flag only when first five status bytes differ
// - Buffer mode 00 discards, 01 fills second buffer when first full, 11 reserved
// - Mode 10: status byte 1 bits 4-7 format when professional, else consumer
// - Double-buffer size 0 gives 384 bits, 1 gives 768; each starts at Z
// - Outgoing subframe validity bit follows transmit validity control bit
// - Rate ratio codes 000 1:1, 001 1:2, 010 1:4, 101 2:1, 110 4:1
// - Clock select 00 internal 1, 01 internal 2, 10 recovered, 11 reserved
// - Transmitter runs only while its enable bit is 1
// - Receiver buffer configuration at address 0x0B, below transmitter control
//------------------------------------------------------------------------------
package sutc_pkg;
    // Register bus
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] RXBUF_CFG_ADDR = 7'h0b;
    localparam logic [6:0] TX_CTRL_ADDR = 7'h0c;
    localparam logic [7:0] RXBUF_CFG_RST = 8'h00;
    localparam logic [7:0] TX_CTRL_RST = 8'h00;
    // Receiver buffer configuration fields
    localparam int UB_ID_ONLY_POS = 5;
    localparam int UB_SPLIT_POS = 4;
    localparam int CS_CHG_POS = 3;
    localparam int UB_MODE_LSB = 1;
    localparam int UB_SIZE_POS = 0;
    // Transmitter control fields
    localparam int TX_VALID_POS = 6;
    localparam int TX_RATIO_LSB = 3;
    localparam int TX_CLKSEL_LSB = 1;
    localparam int TX_ON_POS = 0;
    // User-bit buffer modes
    localparam logic [1:0] UB_MODE_IGNORE = 2'h0;
    localparam logic [1:0] UB_MODE_DOUBLE = 2'h1;
    localparam logic [1:0] UB_MODE_FORMAT = 2'h2;
    // Rate ratio codes
    localparam logic [2:0] RATIO_1_1 = 3'h0;
    localparam logic [2:0] RATIO_1_2 = 3'h1;
    localparam logic [2:0] RATIO_1_4 = 3'h2;
    localparam logic [2:0] RATIO_2_1 = 3'h5;
    localparam logic [2:0] RATIO_4_1 = 3'h6;
    // Transmit clock source codes
    localparam logic [1:0] CLK_INT1 = 2'h0;
    localparam logic [1:0] CLK_INT2 = 2'h1;
    localparam logic [1:0] CLK_RECOV = 2'h2;
    // Stream geometry
    localparam int UB_LEN_SMALL = 384;
    localparam int UB_LEN_LARGE = 768;
    localparam int CS_FRAMES = 192;
    localparam int CS_CMP_BITS = 40;
    localparam int IU_BITS = 8;
    localparam int SF_VALID_POS = 28;
    localparam int SF_PARITY_POS = 31;
    localparam logic [3:0] PRO_MSG_BLOCK = 4'h1;
    localparam logic [6:0] TAPE_CATEGORY_DEF = 7'h03;
endpackage

// >>> rtl/sutc_rx_if.sv
// Receive stream carried from the top to the user-bit and status modules
`timescale 1ns/1ps
interface sutc_rx_if;
    logic stb; // One subframe decoded
    logic chan_b; // Subframe belongs to channel B
    logic zpre; // Subframe carried a Z preamble
    logic user_bit;
    logic cs_bit;
    modport src (output stb, output chan_b, output zpre, output user_bit, output cs_bit);
    modport snk (input stb, input chan_b, input zpre, input user_bit, input cs_bit);
endinterface

// >>> rtl/sutc_cs_monitor.sv
// Channel-status block tracker: block completion and change detection
`timescale 1ns/1ps
module sutc_cs_monitor
    import sutc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    sutc_rx_if.snk rx,
    input wire logic chg_mode,
    output logic blk_evt,
    output logic pro_r,
    output logic [7:0] byte1_r
);
    logic [7:0] frame_r;
    logic in_blk_r;
    logic [CS_CMP_BITS-1:0] cur_r;
    logic [CS_CMP_BITS-1:0] prev_r;
    logic a_stb;
    logic done;
    assign a_stb = rx.stb && !rx.chan_b;
    assign done = a_stb && in_blk_r && !rx.zpre && (frame_r == 8'(CS_FRAMES - 1));

    // Frame count restarts at every Z; an early Z drops the partial block
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_r <= 8'h00;
            in_blk_r <= 1'b0;
        end else if (a_stb && rx.zpre) begin
            frame_r <= 8'h01;
            in_blk_r <= 1'b1;
        end else if (done) begin
            in_blk_r <= 1'b0;
        end else if (a_stb && in_blk_r) begin
            frame_r <= frame_r + 8'h01;
        end
    end

    // First five status bytes of channel A
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_r <= '0;
        end else if (a_stb && rx.zpre) begin
            cur_r[0] <= rx.cs_bit;
        end else if (a_stb && in_blk_r && frame_r < 8'(CS_CMP_BITS)) begin
            cur_r[frame_r[5:0]] <= rx.cs_bit;
        end
    end

    // Block event per mode, history and decoded fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= '0;
            blk_evt <= 1'b0;
            pro_r <= 1'b0;
            byte1_r <= 8'h00;
        end else begin
            blk_evt <= done && (!chg_mode || cur_r != prev_r);
            if (done) begin
                prev_r <= cur_r;
                pro_r <= cur_r[0];
                byte1_r <= cur_r[15:8];
            end
        end
    end
endmodule // sutc_cs_monitor

// >>> rtl/sutc_userbit_buf.sv
// Double-bank receive user-bit store with block and unit framing
`timescale 1ns/1ps
module sutc_userbit_buf
    import sutc_pkg::*;
#(
    parameter int LEN_SMALL = UB_LEN_SMALL,
    parameter int LEN_LARGE = UB_LEN_LARGE
) (
    input wire logic clk,
    input wire logic arst_n,
    sutc_rx_if.snk rx,
    input wire logic [1:0] mode,
    input wire logic split,
    input wire logic size_large,
    input wire logic professional_flag,
    input wire logic [3:0] pro_code,
    input wire logic [$clog2(LEN_LARGE)-1:0] rd_addr,
    output logic rd_data,
    output logic full_evt,
    output logic start_bit_r
);
    localparam int AW = $clog2(2 * LEN_LARGE);
    localparam int CW = $clog2(LEN_LARGE);
    logic mem [0:2*LEN_LARGE-1];
    logic bank_r;
    logic armed_r;
    logic first_r;
    logic [CW-1:0] cnt_r, a_cnt_r, b_cnt_r;
    logic [2:0] iu_r;
    logic blk_mode, iu_mode, store, last;
    logic [CW-1:0] len, half, slot;
    logic [AW-1:0] base;

    // Framing choice: professional block code takes block framing
    always_comb begin
        blk_mode = (mode == UB_MODE_DOUBLE) ||
                   (mode == UB_MODE_FORMAT && professional_flag && pro_code == PRO_MSG_BLOCK);
        iu_mode = (mode == UB_MODE_FORMAT) && !blk_mode;
        len = (mode == UB_MODE_DOUBLE && size_large) ? CW'(LEN_LARGE) : CW'(LEN_SMALL);
        half = len >> 1;
        store = 1'b0;
        if (rx.stb && blk_mode) store = armed_r || rx.zpre;
        if (rx.stb && iu_mode) store = (iu_r != 3'h0) || rx.user_bit;
        if (split && store) store = rx.chan_b ? (b_cnt_r < half) : (a_cnt_r < half);
        if (split) slot = rx.chan_b ? half + b_cnt_r : a_cnt_r;
        else slot = cnt_r;
        base = bank_r ? AW'(LEN_LARGE) : AW'(0);
        last = store && (cnt_r == len - CW'(1));
    end

    // Bit store; no reset on the array
    always_ff @(posedge clk) begin
        if (store) mem[base + AW'(slot)] <= rx.user_bit;
    end

    // Software reads the bank not being filled
    always_ff @(posedge clk) begin
        rd_data <= mem[(bank_r ? AW'(0) : AW'(LEN_LARGE)) + AW'(rd_addr)];
    end

    // Counters and bank swap; discard mode idles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bank_r <= 1'b0;
            armed_r <= 1'b0;
            cnt_r <= '0;
            a_cnt_r <= '0;
            b_cnt_r <= '0;
            iu_r <= 3'h0;
            first_r <= 1'b0;
            start_bit_r <= 1'b0;
            full_evt <= 1'b0;
        end else begin
            full_evt <= last;
            if (mode == UB_MODE_IGNORE || mode == 2'h3) begin
                armed_r <= 1'b0;
                cnt_r <= '0;
                a_cnt_r <= '0;
                b_cnt_r <= '0;
                iu_r <= 3'h0;
            end else if (last) begin
                bank_r <= !bank_r;
                armed_r <= 1'b0; // Next bank waits for Z again
                cnt_r <= '0;
                a_cnt_r <= '0;
                b_cnt_r <= '0;
                iu_r <= 3'h0;
                start_bit_r <= (cnt_r == '0) ? rx.user_bit : first_r;
            end else if (store) begin
                armed_r <= 1'b1;
                if (cnt_r == '0) first_r <= rx.user_bit;
                cnt_r <= cnt_r + CW'(1);
                if (rx.chan_b) b_cnt_r <= b_cnt_r + CW'(1);
                else a_cnt_r <= a_cnt_r + CW'(1);
                if (iu_mode) iu_r <= (iu_r == 3'(IU_BITS - 1)) ? 3'h0 : iu_r + 3'h1;
            end
        end
    end
endmodule // sutc_userbit_buf

// >>> dv/sutc_src_model.sv
// S/PDIF source model: decoded subframes, A then B
`timescale 1ns/1ps
module sutc_src_model (
    input wire logic clk,
    input wire logic go,
    input wire logic slow,
    input wire logic [8:0] frames,
    input wire logic cs_val,
    output logic busy,
    output logic stb,
    output logic chan_b,
    output logic zpre,
    output logic user_bit,
    output logic cs_bit
);
    logic [9:0] sf_r = '0;
    logic [1:0] gap_r = '0;
    initial {busy, stb, chan_b, zpre, user_bit, cs_bit} = '0;
    // Idle lines toggle so a stale value never passes for data
    always @(posedge clk) begin
        stb <= 1'b0;
        {chan_b, zpre, user_bit, cs_bit} <= ~{chan_b, zpre, user_bit, cs_bit};
        gap_r <= gap_r + 2'h1;
        if (go) begin
            {sf_r, gap_r, busy} <= {12'h000, 1'b1};
        end else if (busy && !gap_r[0] && (!gap_r[1] || !slow)) begin
            stb <= 1'b1;
            chan_b <= sf_r[0];
            zpre <= sf_r % 10'd384 == 10'd0; // Z opens every block
            user_bit <= sf_r[0] ^ sf_r[2];
            cs_bit <= cs_val;
            sf_r <= sf_r + 10'd1;
            busy <= sf_r + 10'd1 != {frames, 1'b0};
        end
    end
endmodule // sutc_src_model

// >>> dv/sutc_props.sv
// Concurrent checks on transmit control
`timescale 1ns/1ps
module sutc_props
    import sutc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic tx_sf_valid,
    input wire logic tx_out_valid,
    input wire logic [31:0] tx_out_data,
    input wire logic [2:0] tx_clk_sel_oh,
    input wire logic [2:0] tx_rate_ratio,
    input wire logic tx_on
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Control writes and reserved ratio codes
    sequence s_tx_wr;
        reg_wr && reg_addr == TX_CTRL_ADDR;
    endsequence
    sequence s_rsv_ratio;
        s_tx_wr ##0 reg_wdata[5:3] inside {3'h3, 3'h4, 3'h7};
    endsequence
    property p_on_load;
        s_tx_wr |=> tx_on == $past(reg_wdata[TX_ON_POS]);
    endproperty
    property p_ratio_load;
        s_tx_wr ##0 !(reg_wdata[5:3] inside {3'h3, 3'h4, 3'h7})
            |=> tx_rate_ratio == $past(reg_wdata[5:3]);
    endproperty
    property p_ratio_keep;
        s_rsv_ratio |=> $stable(tx_rate_ratio);
    endproperty
    property p_clk_load;
        s_tx_wr ##0 reg_wdata[2:1] != 2'h3 |=> tx_clk_sel_oh == 3'h1 << $past(reg_wdata[2:1]);
    endproperty
    property p_onehot;
        $onehot(tx_clk_sel_oh);
    endproperty
    property p_pass;
        tx_sf_valid && tx_on |=> tx_out_valid;
    endproperty
    property p_quiet;
        !(tx_sf_valid && tx_on) |=> !tx_out_valid;
    endproperty
    property p_parity;
        tx_out_valid |-> !(^tx_out_data[31:4]);
    endproperty
    a_on_load: assert property (p_on_load) else $error("enable not loaded");
    a_ratio_load: assert property (p_ratio_load) else $error("ratio not loaded");
    a_ratio_keep: assert property (p_ratio_keep) else $error("ratio changed");
    a_clk_load: assert property (p_clk_load) else $error("clock select wrong");
    a_onehot: assert property (p_onehot) else $error("clock select not one-hot");
    a_pass: assert property (p_pass) else $error("subframe not sent");
    a_quiet: assert property (p_quiet) else $error("subframe sent while off");
    a_parity: assert property (p_parity) else $error("subframe parity odd");
endmodule // sutc_props
bind sutc_top sutc_props u_props (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .tx_sf_valid,
    .tx_out_valid, .tx_out_data, .tx_clk_sel_oh, .tx_rate_ratio, .tx_on);

// >>> dv/spdif_userbit_tx_control_tb.sv
// Self-checking bench for the user-bit and transmit control block
`timescale 1ns/1ps
module spdif_userbit_tx_control_tb
    import sutc_pkg::*;
();
    logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_sf_valid = 1'b0;
    logic rx_cs_flag_clr = 1'b0, ub_irq_clr = 1'b0, go = 1'b0, slow = 1'b0, cs_val = 1'b0;
    logic [6:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic [9:0] ub_rd_addr = '0;
    logic [8:0] frames = 9'h008;
    logic [31:0] tx_sf_data = '0, tx_out_data;
    logic [2:0] tx_clk_sel_oh, tx_rate_ratio, cur_ratio = 3'h0;
    logic [1:0] cur_clk = 2'h0;
    logic [15:0] lfsr_r = 16'h000e;
    logic rx_stb, rx_chan_b, rx_zpre, rx_user_bit, rx_cs_bit, ub_rd_data, busy, vld;
    logic rx_cs_block_flag, ub_irq_flag, tx_out_valid, tx_frame_tick, tx_on;
    int n_errors = 0, check_count = 0, ticks = 0, cycles = 0;

    // 10 MHz clock
    always #50 clk = ~clk;
    sutc_top dut_u (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_stb, .rx_chan_b, .rx_zpre, .rx_user_bit, .rx_cs_bit, .ub_rd_addr, .ub_rd_data,
        .rx_cs_block_flag, .rx_cs_flag_clr, .ub_irq_flag, .ub_irq_clr, .tx_sf_valid,
        .tx_sf_data, .tx_out_valid, .tx_out_data, .tx_frame_tick, .tx_clk_sel_oh,
        .tx_rate_ratio, .tx_on);
    sutc_src_model src_u (.clk, .go, .slow, .frames, .cs_val, .busy, .stb(rx_stb),
        .chan_b(rx_chan_b), .zpre(rx_zpre), .user_bit(rx_user_bit), .cs_bit(rx_cs_bit));

    // Tick count and hang guard
    always @(posedge clk) begin
        ticks += (tx_frame_tick === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] exp_tx(input logic [31:0] d, input logic v);
        d[SF_VALID_POS] = v;
        d[SF_PARITY_POS] = ^d[30:4];
        return d;
    endfunction
    function automatic int exp_ticks(input logic [2:0] r, input int n);
        return r == RATIO_1_2 ? n / 2 : r == RATIO_1_4 ? n / 4 :
            r == RATIO_2_1 ? n * 2 : r == RATIO_4_1 ? n * 4 : n;
    endfunction
    // Split store: A low half, B high half
    function automatic logic exp_ub(input int k, input logic split);
        k = !split ? k : (k < UB_LEN_SMALL / 2 ? 2 * k : 2 * k - UB_LEN_SMALL + 1);
        return k[0] ^ k[2];
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check("reg_rdata", exp, reg_rdata);
    endtask
    task automatic send(input logic on);
        lfsr_r = lfsr_next(lfsr_r);
        @(posedge clk);
        {tx_sf_valid, tx_sf_data} <= {1'b1, lfsr_r, ~lfsr_r};
        @(posedge clk);
        tx_sf_valid <= 1'b0;
        #1;
        check("tx_out_valid", on, tx_out_valid);
        if (on) check("tx_out_data", exp_tx(tx_sf_data, vld), tx_out_data);
    endtask
    // Clear flags, stream frames
    task automatic run(input logic s, input logic c);
        @(posedge clk);
        {slow, cs_val, go, rx_cs_flag_clr, ub_irq_clr} <= {s, c, 3'h7};
        @(posedge clk);
        {go, rx_cs_flag_clr, ub_irq_clr} <= 3'h0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------
    // Scenarios
    // ------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        check("tx_clk_sel_oh", 3'h1, tx_clk_sel_oh);
        rd(RXBUF_CFG_ADDR, RXBUF_CFG_RST);
        wr(RXBUF_CFG_ADDR, 8'hc3);
        rd(RXBUF_CFG_ADDR, 8'h03);
        wr(7'h0a, 8'hff);
        rd(7'h0a, 8'h00);
        // All ratio and clock codes; reserved ones ignored
        for (int c = 0; c < 8; c++) begin
            lfsr_r = lfsr_next(lfsr_r);
            vld = lfsr_r[0];
            wr(TX_CTRL_ADDR, {2'h0, cur_ratio, cur_clk, 1'b0});
            wr(TX_CTRL_ADDR, {1'b1, vld, c[2:0], c[1:0], 1'b1});
            if (c[1:0] != 2'h3) cur_clk = c[1:0];
            if (!(c[2:0] inside {3'h3, 3'h4, 3'h7})) cur_ratio = c[2:0];
            rd(TX_CTRL_ADDR, {1'b0, vld, cur_ratio, cur_clk, 1'b1});
            check("tx_rate_ratio", cur_ratio, tx_rate_ratio);
            check("tx_clk_sel_oh", 3'h1 << cur_clk, tx_clk_sel_oh);
            repeat (2) send(1'b1);
            ticks = 0;
            run(1'b1, 1'b0);
            check("tx_frame_tick", exp_ticks(cur_ratio, 8), ticks);
        end
        wr(TX_CTRL_ADDR, 8'h00);
        send(1'b0);
        frames <= 9'(CS_FRAMES);
        wr(RXBUF_CFG_ADDR, 8'h00);
        run(1'b1, 1'b0);
        check("rx_cs_block_flag", 1'b1, rx_cs_block_flag);
        wr(RXBUF_CFG_ADDR, 8'h08);
        for (int c = 0; c < 2; c++) begin
            run(1'b1, c[0]);
            check("rx_cs_block_flag", c[0], rx_cs_block_flag);
        end
        // Interleaved, split, then discarded user bits
        for (int s = 0; s < 3; s++) begin
            wr(RXBUF_CFG_ADDR, s == 0 ? 8'h02 : (s == 1 ? 8'h12 : 8'h00));
            run(1'b0, 1'b0);
            check("ub_irq_flag", s != 2, ub_irq_flag);
            for (int k = 188; k < 196 && s < 2; k++) begin
                @(posedge clk);
                ub_rd_addr <= 10'(k);
                repeat (2) @(posedge clk);
                check("ub_rd_data", exp_ub(k, s == 1), ub_rd_data);
            end
        end
        stop_test();
    end
endmodule // spdif_userbit_tx_control_tb
